// ### asu_consts.svh
// Offsets, field positions, reset values and timing counts of the serial unit.
// Assumes inclusion by the unit and the bench only; definitions only.
`ifndef ASU_CONSTS_SVH
`define ASU_CONSTS_SVH
`define ASU_OFF_MODE 8'h00
`define ASU_OFF_CTRL 8'h04
`define ASU_OFF_STAT 8'h08
`define ASU_OFF_TXD 8'h0C
`define ASU_OFF_RXD 8'h10
`define ASU_OFF_BAUD 8'h14
// serial_mode_reg fields
`define ASU_M_SEVEN 0
`define ASU_M_PAR 1
`define ASU_M_ODD 2
`define ASU_M_TWO_STOP 3
`define ASU_M_TAG 4
// serial_ctrl_reg fields
`define ASU_C_TX_ON 0
`define ASU_C_RX_ON 1
`define ASU_C_TX_IRQ 2
`define ASU_C_TXD_IRQ 3
`define ASU_C_RX_IRQ 4
`define ASU_C_CLK_LO 5
`define ASU_C_CLK_HI 6
// serial_status_reg fields
`define ASU_S_TX_EMPTY 0
`define ASU_S_TX_DONE 1
`define ASU_S_RX_FULL 2
`define ASU_S_OVERRUN 3
`define ASU_S_FRAME 4
`define ASU_S_PARITY 5
`define ASU_S_TAG_TX 6
`define ASU_S_TAG_RX 7
// Reset values and timing
`define ASU_RST_MODE 8'h00
`define ASU_RST_CTRL 8'h00
`define ASU_RST_BAUD 16'h0000
`define ASU_PH_LAST 4'hF
`define ASU_PH_SAMPLE 4'h7
`define ASU_PH_CLK_RISE 4'h8
`define ASU_BITS_8 4'h7
`define ASU_BITS_7 4'h6
`endif

// ### asu_pkg.sv
// Types of the asynchronous serial unit: state enums and the state record.
// Assumes asu_consts.svh alongside for the numeric constants.
package asu_pkg;
    typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_TAG, TX_STOP} asu_tx_e;
    typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_TAG, RX_STOP} asu_rx_e;
    typedef struct packed {
        logic [7:0] mode;
        logic [7:0] ctrl;
        logic [15:0] baud_div;
        logic [15:0] baud_cnt;
        logic tx_empty;
        logic tx_done;
        logic rx_full;
        logic overrun;
        logic frame_fault;
        logic parity_fault;
        logic tag_tx;
        logic tag_rx;
        logic [7:0] tx_hold;
        logic [7:0] tx_shift;
        logic tx_extra;
        logic tx_next;
        logic tx_out;
        logic sck;
        asu_tx_e tx_st;
        logic [3:0] tx_ph;
        logic [3:0] tx_cnt;
        asu_rx_e rx_st;
        logic [3:0] rx_ph;
        logic [3:0] rx_cnt;
        logic [7:0] rx_shift;
        logic rx_extra;
        logic [7:0] rx_hold;
        logic [2:0] rxs;
        logic [2:0] cks;
        logic [31:0] prdata;
    } asu_state_s;
endpackage : asu_pkg

// ### asu_uart.sv
// Asynchronous serial unit: APB registers, baud tick, transmitter, receiver.
// Assumes a zero-wait APB master and a remote peer on RX_LINE/TX_LINE.
// Summary of operation
// - Frame: low start, data, option, high stops
// - Idle line high; falling edge starts reception
// - Sixteen formats from mode register fields
// - Independent double-buffered transmitter and receiver
// - Basic clock is sixteen times bit rate
// - Sync on start edge, sample eighth pulse
// - Clock output rises mid transmitted bit
// - Transmit disable forces empty flag set
// - Receive disable keeps flags and buffer
// - Load shift stage, set empty, start
// - Send start, data, option bit, stops
// - At stop, pending character follows immediately
// - At stop, nothing pending sets done flag
// - Receiver shifts character, checks parity, stop
// - Full buffer on completion: overrun, discard
// - Parity mismatch sets fault, keeps character
// - Low stop bit sets frame fault
// - Clean completion stores character, sets full
// - Errors halt reception until flags cleared
//
// Implementation choices: the register addresses and the APB interface to the registers.
`include "asu_consts.svh"
module asu_uart
    import asu_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic TX_LINE,
    input wire logic RX_LINE,
    input wire logic SERIAL_CLK_I,
    output logic SERIAL_CLK_O,
    output logic SERIAL_CLK_OE,
    output logic TX_EMPTY_IRQ,
    output logic TX_DONE_IRQ,
    output logic RX_FULL_IRQ,
    output logic RX_ERROR_IRQ
);
    asu_state_s q;
    asu_state_s next_q;
    logic tick;
    logic tx_bnd;
    logic rx_smp;
    logic rx_bit;
    logic rx_fall;
    logic rx_err;
    logic rx_done;
    logic go_stop;
    logic has_extra;
    logic [3:0] last_bit;
    logic [7:0] rx_data;
    logic par_bad;
    logic wr;
    logic mapped;
    logic [31:0] rd_mux;

    assign mapped = (PADDR == `ASU_OFF_MODE) || (PADDR == `ASU_OFF_CTRL)
        || (PADDR == `ASU_OFF_STAT) || (PADDR == `ASU_OFF_TXD)
        || (PADDR == `ASU_OFF_RXD) || (PADDR == `ASU_OFF_BAUD);
    assign wr = PSEL && PENABLE && PWRITE && mapped;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !mapped;
    assign PRDATA = q.prdata;
    assign TX_LINE = q.tx_out;
    assign SERIAL_CLK_O = q.sck;
    // Clock drives out only on internal source with output on
    assign SERIAL_CLK_OE = !q.ctrl[`ASU_C_CLK_HI] && q.ctrl[`ASU_C_CLK_LO];
    assign TX_EMPTY_IRQ = q.tx_empty && q.ctrl[`ASU_C_TX_IRQ];
    assign TX_DONE_IRQ = q.tx_done && q.ctrl[`ASU_C_TXD_IRQ];
    assign RX_FULL_IRQ = q.rx_full && q.ctrl[`ASU_C_RX_IRQ];
    assign rx_err = q.overrun || q.frame_fault || q.parity_fault;
    assign RX_ERROR_IRQ = rx_err && q.ctrl[`ASU_C_RX_IRQ];
    // Tag format overrides parity enable
    assign has_extra = q.mode[`ASU_M_TAG] || q.mode[`ASU_M_PAR];
    assign last_bit = q.mode[`ASU_M_SEVEN] ? `ASU_BITS_7 : `ASU_BITS_8;
    assign tx_bnd = tick && (q.tx_ph == `ASU_PH_LAST);
    assign rx_smp = tick && (q.rx_ph == `ASU_PH_SAMPLE);
    assign rx_bit = q.rxs[1];
    assign rx_fall = q.rxs[2] && !q.rxs[1];
    assign rx_data = q.mode[`ASU_M_SEVEN] ? {1'b0, q.rx_shift[7:1]} : q.rx_shift;
    assign par_bad = q.mode[`ASU_M_PAR] && !q.mode[`ASU_M_TAG]
        && ((^rx_data ^ q.rx_extra) != q.mode[`ASU_M_ODD]);
    assign rx_done = (q.rx_st == RX_STOP) && rx_smp;

    always_comb begin
        rd_mux = 32'h0000_0000;
        case (PADDR)
            `ASU_OFF_MODE: rd_mux[7:0] = q.mode;
            `ASU_OFF_CTRL: rd_mux[7:0] = q.ctrl;
            `ASU_OFF_STAT: rd_mux[7:0] = {q.tag_rx, q.tag_tx, q.parity_fault,
                q.frame_fault, q.overrun, q.rx_full, q.tx_done, q.tx_empty};
            `ASU_OFF_TXD: rd_mux[7:0] = q.tx_hold;
            `ASU_OFF_RXD: rd_mux[7:0] = q.rx_hold;
            `ASU_OFF_BAUD: rd_mux[15:0] = q.baud_div;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_comb begin
        next_q = q;
        go_stop = 1'b0;
        // Sixteen-times tick: internal divider or synchronised pin edges
        next_q.cks = {q.cks[1:0], SERIAL_CLK_I};
        next_q.rxs = {q.rxs[1:0], RX_LINE};
        if (q.ctrl[`ASU_C_CLK_HI]) begin
            tick = q.cks[1] && !q.cks[2];
            next_q.baud_cnt = 16'h0000;
        end else begin
            tick = (q.baud_cnt == q.baud_div);
            next_q.baud_cnt = tick ? 16'h0000 : q.baud_cnt + 16'h0001;
        end
        // APB side
        if (PSEL && !PENABLE) begin
            next_q.prdata = rd_mux;
        end
        if (wr) begin
            case (PADDR)
                `ASU_OFF_MODE: next_q.mode = PWDATA[7:0];
                `ASU_OFF_CTRL: next_q.ctrl = PWDATA[7:0];
                `ASU_OFF_STAT: begin
                    // Write zero clears; a same-cycle hardware set wins below
                    next_q.tx_done = q.tx_done && PWDATA[`ASU_S_TX_DONE];
                    next_q.rx_full = q.rx_full && PWDATA[`ASU_S_RX_FULL];
                    next_q.overrun = q.overrun && PWDATA[`ASU_S_OVERRUN];
                    next_q.frame_fault = q.frame_fault && PWDATA[`ASU_S_FRAME];
                    next_q.parity_fault = q.parity_fault && PWDATA[`ASU_S_PARITY];
                    next_q.tag_tx = PWDATA[`ASU_S_TAG_TX];
                end
                `ASU_OFF_TXD: begin
                    next_q.tx_hold = PWDATA[7:0];
                    next_q.tx_empty = 1'b0;
                    next_q.tx_done = 1'b0;
                end
                `ASU_OFF_BAUD: next_q.baud_div = PWDATA[15:0];
                default: next_q.baud_div = q.baud_div;
            endcase
        end
        // Transmitter; phase runs freely so the clock output keeps its cadence
        if (tick) begin
            next_q.tx_ph = q.tx_ph + 4'h1;
        end
        case (q.tx_st)
            TX_IDLE: begin
                if (tx_bnd && q.ctrl[`ASU_C_TX_ON] && !q.tx_empty) begin
                    next_q.tx_shift = q.tx_hold;
                    next_q.tx_extra = q.mode[`ASU_M_TAG] ? q.tag_tx
                        : (^q.tx_hold[6:0] ^ (q.tx_hold[7] && !q.mode[`ASU_M_SEVEN])
                        ^ q.mode[`ASU_M_ODD]);
                    next_q.tx_empty = 1'b1;
                    next_q.tx_st = TX_START;
                end
            end
            TX_START: begin
                if (tx_bnd) begin
                    next_q.tx_st = TX_DATA;
                    next_q.tx_cnt = 4'h0;
                end
            end
            TX_DATA: begin
                if (tx_bnd) begin
                    next_q.tx_shift = {1'b0, q.tx_shift[7:1]};
                    next_q.tx_cnt = q.tx_cnt + 4'h1;
                    if (q.tx_cnt == last_bit) begin
                        next_q.tx_st = has_extra ? TX_TAG : TX_STOP;
                        go_stop = !has_extra;
                    end
                end
            end
            TX_TAG: begin
                if (tx_bnd) begin
                    next_q.tx_st = TX_STOP;
                    go_stop = 1'b1;
                end
            end
            TX_STOP: begin
                if (tx_bnd) begin
                    if (q.mode[`ASU_M_TWO_STOP] && q.tx_cnt == 4'h0) begin
                        next_q.tx_cnt = 4'h1;
                    end else begin
                        next_q.tx_st = q.tx_next ? TX_START : TX_IDLE;
                        next_q.tx_next = 1'b0;
                    end
                end
            end
            default: next_q.tx_st = TX_IDLE;
        endcase
        if (go_stop) begin
            next_q.tx_cnt = 4'h0;
            // Pending character is taken at stop-bit entry, keeping frames gapless
            if (q.ctrl[`ASU_C_TX_ON] && !next_q.tx_empty) begin
                next_q.tx_shift = next_q.tx_hold;
                next_q.tx_extra = q.mode[`ASU_M_TAG] ? next_q.tag_tx
                    : (^next_q.tx_hold[6:0]
                    ^ (next_q.tx_hold[7] && !q.mode[`ASU_M_SEVEN]) ^ q.mode[`ASU_M_ODD]);
                next_q.tx_empty = 1'b1;
                next_q.tx_next = 1'b1;
            end else begin
                next_q.tx_done = 1'b1;
            end
        end
        if (!q.ctrl[`ASU_C_TX_ON]) begin
            next_q.tx_st = TX_IDLE;
            next_q.tx_next = 1'b0;
            next_q.tx_empty = 1'b1;
        end
        case (next_q.tx_st)
            TX_START: next_q.tx_out = 1'b0;
            TX_DATA: next_q.tx_out = next_q.tx_shift[0];
            TX_TAG: next_q.tx_out = next_q.tx_extra;
            default: next_q.tx_out = 1'b1;
        endcase
        next_q.sck = next_q.tx_ph[3];
        // Receiver
        if (q.rx_st != RX_IDLE && tick) begin
            next_q.rx_ph = q.rx_ph + 4'h1;
        end
        case (q.rx_st)
            RX_IDLE: begin
                if (q.ctrl[`ASU_C_RX_ON] && !rx_err && rx_fall) begin
                    next_q.rx_st = RX_START;
                    next_q.rx_ph = 4'h0;
                end
            end
            RX_START: begin
                if (rx_smp) begin
                    // A glitch shorter than half a bit is not a start bit
                    next_q.rx_st = rx_bit ? RX_IDLE : RX_DATA;
                    next_q.rx_cnt = 4'h0;
                end
            end
            RX_DATA: begin
                if (rx_smp) begin
                    next_q.rx_shift = {rx_bit, q.rx_shift[7:1]};
                    next_q.rx_cnt = q.rx_cnt + 4'h1;
                    if (q.rx_cnt == last_bit) begin
                        next_q.rx_st = has_extra ? RX_TAG : RX_STOP;
                    end
                end
            end
            RX_TAG: begin
                if (rx_smp) begin
                    next_q.rx_extra = rx_bit;
                    next_q.rx_st = RX_STOP;
                end
            end
            RX_STOP: begin
                if (rx_smp) begin
                    next_q.rx_st = RX_IDLE;
                    next_q.frame_fault = next_q.frame_fault || !rx_bit;
                    next_q.parity_fault = next_q.parity_fault || par_bad;
                    if (q.rx_full) begin
                        next_q.overrun = 1'b1;
                        next_q.rx_full = 1'b1;
                    end else begin
                        next_q.rx_hold = rx_data;
                        next_q.tag_rx = q.mode[`ASU_M_TAG] && q.rx_extra;
                        next_q.rx_full = next_q.rx_full || (rx_bit && !par_bad);
                    end
                end
            end
            default: next_q.rx_st = RX_IDLE;
        endcase
        if (!q.ctrl[`ASU_C_RX_ON] && q.rx_st != RX_STOP) begin
            next_q.rx_st = RX_IDLE;
        end
        if (!q.ctrl[`ASU_C_RX_ON] && q.rx_st == RX_STOP) begin
            next_q.rx_st = RX_IDLE;
            next_q.rx_hold = q.rx_hold;
            next_q.rx_full = q.rx_full;
            next_q.overrun = q.overrun;
            next_q.frame_fault = q.frame_fault;
            next_q.parity_fault = q.parity_fault;
            next_q.tag_rx = q.tag_rx;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            q <= '0;
            q.mode <= `ASU_RST_MODE;
            q.ctrl <= `ASU_RST_CTRL;
            q.baud_div <= `ASU_RST_BAUD;
            q.tx_empty <= 1'b1;
            q.tx_out <= 1'b1;
            q.rxs <= 3'h7;
            q.tx_st <= TX_IDLE;
            q.rx_st <= RX_IDLE;
        end else begin
            q <= next_q;
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);

    sequence s_tx_go;
        q.tx_st == TX_IDLE && tx_bnd && q.ctrl[`ASU_C_TX_ON] && !q.tx_empty;
    endsequence
    sequence s_tx_started;
        q.tx_st == TX_START && q.tx_empty && !TX_LINE;
    endsequence
    sequence s_rx_clean;
        rx_done && !q.rx_full && rx_bit && !par_bad && q.ctrl[`ASU_C_RX_ON];
    endsequence

    a_tx_off_empty: assert property (!q.ctrl[`ASU_C_TX_ON] |=> q.tx_empty)
        else $error("empty flag not forced with transmitter off");
    a_tx_load_start: assert property (s_tx_go |=> s_tx_started)
        else $error("transmitter did not load and start");
    a_idle_line: assert property (q.tx_st == TX_IDLE |-> TX_LINE)
        else $error("line not high while idle");
    a_stop_high: assert property (q.tx_st == TX_STOP |-> TX_LINE)
        else $error("stop bit not high");
    a_clk_mid_bit: assert property ($rose(SERIAL_CLK_O) |-> q.tx_ph == `ASU_PH_CLK_RISE)
        else $error("clock output edge not mid bit");
    a_rx_overrun: assert property (rx_done && q.rx_full && q.ctrl[`ASU_C_RX_ON]
        |=> q.overrun && q.rx_full && $stable(q.rx_hold))
        else $error("overrun not flagged or data not discarded");
    a_rx_clean_store: assert property (s_rx_clean |=> q.rx_full
        && q.rx_hold == $past(rx_data))
        else $error("clean character not stored");
    a_rx_halted: assert property (q.rx_st == RX_IDLE && rx_err |=> q.rx_st == RX_IDLE)
        else $error("reception resumed with an error flag set");
    a_rx_frame: assert property (rx_done && !rx_bit && q.ctrl[`ASU_C_RX_ON]
        |=> q.frame_fault && !$changed(q.rx_full))
        else $error("frame fault missing or full flag changed");
    a_rx_off_keep: assert property (!q.ctrl[`ASU_C_RX_ON] && !wr
        |=> $stable(q.rx_hold) && $stable(q.rx_full))
        else $error("receive disable altered receive state");
    a_start_sample: assert property (q.rx_st == RX_START && tick && q.rx_ph == 4'h7
        && !rx_bit && q.ctrl[`ASU_C_RX_ON] |=> q.rx_st == RX_DATA)
        else $error("start bit not confirmed at eighth pulse");
endmodule : asu_uart

// ### asu_peer.sv
// Remote serial peer: captures frames from the unit and sends frames to it.
// Assumes 16 clocks per bit (divisor at reset value) and a line idling high.
module asu_peer (
    input wire logic clk,
    input wire logic line_in,
    output logic line_out
);
    timeunit 1ns;
    timeprecision 100ps;
    // Bit length in clocks; the bench retunes it for an external source
    int bit_clks = 16;
    logic [11:0] frames[$];
    realtime starts[$];
    logic [11:0] f;
    initial line_out = 1'b1;
    // Twelve mid-bit samples; short frames pad with idle ones
    always begin
        @(negedge line_in);
        starts.push_back($realtime);
        repeat (bit_clks / 2) @(posedge clk);
        for (int i = 0; i < 12; i++) begin
            f[i] = line_in;
            // No wait after the last sample, so a back-to-back start is not missed
            if (i < 11) repeat (bit_clks) @(posedge clk);
        end
        frames.push_back(f);
    end
    task automatic send(input logic [11:0] fr, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            line_out <= fr[i];
            repeat (bit_clks - 1) @(posedge clk);
        end
        @(posedge clk);
        line_out <= 1'b1;
    endtask : send
endmodule : asu_peer

// ### async_serial_transceiver_test.sv
// Self-checking bench of the serial unit over APB with a remote peer.
// Assumes divisor 0 (16 clocks per bit) and the internal clock source, except t_ext, which uses the external source.
`include "asu_consts.svh"
module async_serial_transceiver_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic CLK = 0, RESET = 1, PSEL = 0, PENABLE = 0, PWRITE = 0;
    logic [7:0] PADDR = '0;
    logic [31:0] PWDATA = '0;
    logic [31:0] PRDATA, q;
    logic PREADY, PSLVERR, TX_LINE, RX_LINE, SERIAL_CLK_O, SERIAL_CLK_OE, err;
    logic TX_EMPTY_IRQ, TX_DONE_IRQ, RX_FULL_IRQ, RX_ERROR_IRQ;
    logic [11:0] fr;
    logic txl_q = 1'b1, ck_q = 1'b0, ext_ck = 1'b0;
    int failures = 0, checks = 0, since = 0;
    always #2.5 CLK = ~CLK;
    // External basic clock runs freely, also through initialisation
    always @(posedge CLK) ext_ck <= ~ext_ck;
    asu_uart u_asu_uart (.CLK(CLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .TX_LINE(TX_LINE), .RX_LINE(RX_LINE), .SERIAL_CLK_I(ext_ck),
        .SERIAL_CLK_O(SERIAL_CLK_O), .SERIAL_CLK_OE(SERIAL_CLK_OE),
        .TX_EMPTY_IRQ(TX_EMPTY_IRQ), .TX_DONE_IRQ(TX_DONE_IRQ),
        .RX_FULL_IRQ(RX_FULL_IRQ), .RX_ERROR_IRQ(RX_ERROR_IRQ));
    asu_peer u_asu_peer (.clk(CLK), .line_in(TX_LINE), .line_out(RX_LINE));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk
    task test_done;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : test_done
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        if (PREADY !== 1'b1) begin
            chk(0, 1, "ready wait");
            test_done();
        end
        q = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask : apb
    task automatic wait_stat(input logic [31:0] m);
        int n;
        n = 0;
        do begin
            apb(0, `ASU_OFF_STAT, 0);
            n++;
        end while ((q & m) !== m && n < 400);
        if ((q & m) !== m) begin
            chk(q, m, "status wait");
            test_done();
        end
    endtask : wait_stat
    task automatic wait_frame;
        int n;
        n = 0;
        while (u_asu_peer.frames.size() == 0 && n < 2000) begin
            @(posedge CLK);
            n++;
        end
        if (n >= 2000) begin
            chk(0, 1, "no frame");
            test_done();
        end
        fr = u_asu_peer.frames.pop_front();
    endtask : wait_frame
    function automatic logic [11:0] mkf(input logic [7:0] d, input logic [4:0] m,
        input logic tag);
        logic [11:0] f;
        int nb;
        f = '1;
        f[0] = 1'b0;
        nb = m[`ASU_M_SEVEN] ? 7 : 8;
        for (int i = 0; i < nb; i++) f[1 + i] = d[i];
        if (m[`ASU_M_TAG]) f[nb + 1] = tag;
        else if (m[`ASU_M_PAR]) f[nb + 1] = (nb == 7 ? ^d[6:0] : ^d) ^ m[`ASU_M_ODD];
        return f;
    endfunction : mkf
    // Clock out must rise mid-bit: 8 clocks after a line change, small slack
    always @(negedge CLK) begin
        if (SERIAL_CLK_OE === 1'b1 && SERIAL_CLK_O === 1'b1 && ck_q === 1'b0 && since < 192)
            chk((since % 16) inside {[6:10]}, 1, "clock phase");
        since <= (TX_LINE !== txl_q) ? 0 : since + 1;
        txl_q <= TX_LINE;
        ck_q <= SERIAL_CLK_O;
    end
    task automatic t_reset;
        apb(0, `ASU_OFF_MODE, 0);
        chk(q, 0, "mode reset");
        apb(0, `ASU_OFF_BAUD, 0);
        chk(q, 0, "baud reset");
        apb(0, `ASU_OFF_STAT, 0);
        chk(q[0], 1, "empty reset");
        apb(0, 8'h40, 0);
        chk({err, q}, {1'b1, 32'h0}, "unmapped");
    endtask : t_reset
    task automatic t_formats;
        logic [7:0] d;
        for (int i = 0; i < 32; i++) begin
            d = 8'hA6 + i[7:0];
            apb(1, `ASU_OFF_CTRL, 0);
            apb(1, `ASU_OFF_MODE, i);
            apb(1, `ASU_OFF_STAT, {i[0], 6'h03});
            apb(1, `ASU_OFF_CTRL, 8'h2D);
            apb(1, `ASU_OFF_TXD, d);
            wait_stat(1);
            chk(TX_EMPTY_IRQ, 1, "empty irq");
            wait_frame();
            chk(fr, mkf(d, i[4:0], i[0]), "frame");
            apb(0, `ASU_OFF_STAT, 0);
            chk({TX_DONE_IRQ, q[1:0]}, 3'b111, "done");
        end
    endtask : t_formats
    task automatic t_b2b;
        apb(1, `ASU_OFF_CTRL, 0);
        apb(1, `ASU_OFF_MODE, 8'h0A);
        apb(1, `ASU_OFF_CTRL, 8'h29);
        u_asu_peer.starts.delete();
        apb(1, `ASU_OFF_TXD, 8'h3C);
        wait_stat(1);
        apb(1, `ASU_OFF_TXD, 8'hC5);
        apb(0, `ASU_OFF_STAT, 0);
        chk(q[1:0], 0, "pending");
        wait_frame();
        chk(fr, mkf(8'h3C, 5'h0A, 0), "first");
        wait_frame();
        chk(fr, mkf(8'hC5, 5'h0A, 0), "second");
        chk(u_asu_peer.starts[1] - u_asu_peer.starts[0] == 960.0, 1, "gap");
    endtask : t_b2b
    task automatic t_abort;
        apb(1, `ASU_OFF_CTRL, 8'h01);
        apb(1, `ASU_OFF_TXD, 8'h11);
        wait_stat(1);
        apb(1, `ASU_OFF_TXD, 8'h22);
        apb(0, `ASU_OFF_STAT, 0);
        chk(q[0], 0, "held");
        apb(1, `ASU_OFF_CTRL, 0);
        apb(0, `ASU_OFF_STAT, 0);
        chk(q[0], 1, "forced empty");
        repeat (400) @(posedge CLK);
        chk(TX_LINE, 1, "tx off idle");
        u_asu_peer.frames.delete();
    endtask : t_abort
    // External source: one tick per two clocks, so 32 clocks per bit
    task automatic t_ext;
        apb(1, `ASU_OFF_CTRL, 0);
        apb(1, `ASU_OFF_MODE, 0);
        apb(1, `ASU_OFF_CTRL, 8'h41);
        u_asu_peer.bit_clks = 32;
        apb(1, `ASU_OFF_TXD, 8'h96);
        wait_frame();
        chk(fr, mkf(8'h96, 0, 0), "external clock frame");
        apb(1, `ASU_OFF_CTRL, 0);
        u_asu_peer.bit_clks = 16;
    endtask : t_ext
    task automatic t_rx;
        logic [11:0] f;
        apb(1, `ASU_OFF_MODE, 0);
        apb(1, `ASU_OFF_STAT, 0);
        apb(1, `ASU_OFF_CTRL, 8'h13);
        apb(1, `ASU_OFF_TXD, 8'hA5);
        u_asu_peer.send(mkf(8'h5A, 0, 0), 10);
        wait_stat(4);
        chk(RX_FULL_IRQ, 1, "full irq");
        apb(0, `ASU_OFF_RXD, 0);
        chk(q, 8'h5A, "rx data");
        wait_frame();
        chk(fr, mkf(8'hA5, 0, 0), "duplex");
        u_asu_peer.send(mkf(8'hC3, 0, 0), 10);
        wait_stat(8);
        chk({RX_ERROR_IRQ, q[5:2]}, 5'b10011, "overrun");
        u_asu_peer.send(mkf(8'h77, 0, 0), 10);
        repeat (20) @(posedge CLK);
        apb(1, `ASU_OFF_CTRL, 0);
        apb(0, `ASU_OFF_STAT, 0);
        chk(q[5:2], 4'b0011, "rx off flags");
        apb(0, `ASU_OFF_RXD, 0);
        chk(q, 8'h5A, "kept data");
        apb(1, `ASU_OFF_STAT, 0);
        u_asu_peer.send(mkf(8'h66, 0, 0), 10);
        repeat (20) @(posedge CLK);
        apb(0, `ASU_OFF_STAT, 0);
        chk(q[5:2], 0, "rx off");
        apb(1, `ASU_OFF_MODE, 8'h02);
        apb(1, `ASU_OFF_CTRL, 8'h12);
        f = mkf(8'h3C, 5'h02, 0);
        f[9] = ~f[9];
        u_asu_peer.send(f, 11);
        wait_stat(32);
        chk({RX_ERROR_IRQ, q[2]}, 2'b10, "parity");
        apb(0, `ASU_OFF_RXD, 0);
        chk(q, 8'h3C, "parity data");
        apb(1, `ASU_OFF_CTRL, 0);
        apb(1, `ASU_OFF_STAT, 0);
        apb(1, `ASU_OFF_MODE, 0);
        apb(1, `ASU_OFF_CTRL, 8'h12);
        f = mkf(8'h81, 0, 0);
        f[9] = 1'b0;
        u_asu_peer.send(f, 10);
        wait_stat(16);
        chk(q[2], 0, "frame full");
        apb(0, `ASU_OFF_RXD, 0);
        chk(q, 8'h81, "frame data");
        u_asu_peer.send(mkf(8'h44, 0, 0), 10);
        repeat (20) @(posedge CLK);
        apb(0, `ASU_OFF_RXD, 0);
        chk(q, 8'h81, "halted");
        apb(1, `ASU_OFF_STAT, 0);
        u_asu_peer.send(mkf(8'h44, 0, 0), 10);
        wait_stat(4);
        apb(0, `ASU_OFF_RXD, 0);
        chk(q, 8'h44, "resumed");
    endtask : t_rx
    initial begin
        repeat (2) @(posedge CLK);
        RESET <= 1'b0;
        t_reset();
        t_formats();
        t_b2b();
        t_abort();
        t_ext();
        t_rx();
        test_done();
    end
    // Hang guard: the whole run needs well under this
    initial begin
        #300us;
        chk(0, 1, "run time");
        test_done();
    end
endmodule : async_serial_transceiver_test
